// ### ucg_clock_gen.sv
// USB PLL clock generator: prescaler, PLL lock model, two branches, register slave
module ucg_clock_gen #(
    parameter int LOCK_TICKS = 64
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic osc_in,
    input wire logic usb_enable,
    input wire logic [ucg_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ucg_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ucg_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ucg_pkg::AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic usb_clk_tick,
    output logic sys_clk_tick,
    output logic pll_locked,
    output logic usb_clk_ready
);
    import ucg_pkg::*;

    // Lock count must fit its counter and be nonzero
    if (LOCK_TICKS < 1 || LOCK_TICKS > 65535) begin : g_bad_lock
        $error("ucg_clock_gen: LOCK_TICKS out of range");
    end

    // Prescale ratio for each select value
    function automatic logic [3:0] prescale_ratio(input logic [2:0] sel);
        case (sel)
            3'h0: prescale_ratio = 4'h1;
            3'h1: prescale_ratio = 4'h2;
            3'h2: prescale_ratio = 4'h3;
            3'h3: prescale_ratio = 4'h4;
            3'h4: prescale_ratio = 4'h5;
            3'h5: prescale_ratio = 4'h6;
            3'h6: prescale_ratio = 4'h8;
            default: prescale_ratio = 4'hC;
        endcase
    endfunction : prescale_ratio

    // Byte address to register index
    function automatic logic [IDX_W-1:0] reg_index(input logic [AXI_ADDR_W-1:0] addr);
        reg_index = addr[IDX_LSB +: IDX_W];
    endfunction : reg_index

    // Index names a mapped register
    function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
        is_mapped = (idx == IDX_OSC_CTRL) || (idx == IDX_CLK_DIV) || (idx == IDX_RC_TUNE)
            || (idx == IDX_REFO_CTRL) || (idx == IDX_USB_CFG);
    endfunction : is_mapped

    // Byte-lane merge limited to writable bits
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wdata,
                                         input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        merge = (old & ~lanes) | (wdata[15:0] & lanes);
    endfunction : merge

    // Register storage
    logic [15:0] osc_ctrl; // Writable oscillator control bits
    logic [2:0] cur_src; // Current oscillator source
    logic [15:0] clk_div; // Clock divider control
    logic [15:0] rc_tune; // RC tuning, stored only
    logic [15:0] refo_ctrl; // Reference output control, stored only
    logic [2:0] prescale_sel; // pll_input_prescale_select

    // Oscillator pin synchroniser and edge
    logic osc_meta; // First stage, read only by osc_sync
    logic osc_sync; // Second stage
    logic osc_prev; // Delayed for edge detect
    logic osc_rise; // Rising edge of the oscillator

    // Prescaler and PLL model
    logic [3:0] pre_cnt; // Oscillator edges in this reference period
    logic ref_tick; // 4 MHz reference event
    logic [15:0] lock_cnt; // Reference ticks since enable
    logic [7:0] gap_cnt; // Cycles since last reference tick
    logic pll_en; // Multiplier enabled
    logic locked; // Multiplier lock
    logic primary_mode; // Primary source selected
    logic usb_allowed; // USB branch may run

    // Bus handshake state
    logic wr_go; // Write taken this cycle
    logic rd_go; // Read taken this cycle

    ucg_branch_if usb_br ();
    ucg_branch_if sys_br ();

    // Two flops before anything looks at the pin
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= osc_in;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign osc_rise = osc_sync & ~osc_prev;

    // Prescaler: no rate sensing, software picks the ratio
    // Limitation: the pin is sampled, so inputs above half of sys_clk alias
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre_cnt <= '0;
            ref_tick <= 1'b0;
        end else if (!pll_en) begin
            pre_cnt <= '0;
            ref_tick <= 1'b0;
        end else if (osc_rise) begin
            if (pre_cnt >= prescale_ratio(prescale_sel) - 4'h1) begin
                pre_cnt <= '0;
                ref_tick <= 1'b1;
            end else begin
                pre_cnt <= pre_cnt + 4'h1;
                ref_tick <= 1'b0;
            end
        end else begin
            ref_tick <= 1'b0;
        end
    end

    // Multiplier runs for USB, for the PLL enable bit, or in PLL mode
    assign primary_mode = (cur_src == SRC_PRIMARY) || (cur_src == SRC_PRIMARY_PLL);
    assign pll_en = usb_enable | clk_div[PLLEN_BIT] | (cur_src == SRC_PRIMARY_PLL);

    // Lock after enough reference ticks; a missing reference drops lock
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lock_cnt <= '0;
            gap_cnt <= '0;
            locked <= 1'b0;
        end else if (!pll_en || gap_cnt >= 8'(REF_GAP_CYC)) begin
            lock_cnt <= '0;
            gap_cnt <= '0;
            locked <= 1'b0;
        end else if (ref_tick) begin
            gap_cnt <= '0;
            if (lock_cnt >= 16'(LOCK_TICKS - 1)) begin
                locked <= 1'b1;
            end else begin
                lock_cnt <= lock_cnt + 16'h0001;
            end
        end else begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    // USB needs a primary source and a locked multiplier
    assign usb_allowed = usb_enable & primary_mode & locked;

    // Both branches share the one 96 MHz source
    assign usb_br.run = usb_allowed;
    assign usb_br.inc = RATE_W'(PLL_OUT_MHZ);
    assign usb_br.modulus = RATE_W'(SYS_CLK_MHZ * USB_DIV);
    assign sys_br.run = locked;
    assign sys_br.inc = RATE_W'(PLL_OUT_MHZ);
    // Fixed three, then post-divide of one, two, four or eight
    assign sys_br.modulus = RATE_W'(SYS_CLK_MHZ * SYS_DIV) << clk_div[SYSTEM_CLOCK_POST_DIVIDE_SELECT_LSB +: 2];

    ucg_rate_divider #(
        .ACC_W(RATE_W)
    ) u_usb_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .br(usb_br.div)
    );

    ucg_rate_divider #(
        .ACC_W(RATE_W)
    ) u_sys_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .br(sys_br.div)
    );

    // Outputs from flops
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            usb_clk_tick <= 1'b0;
            sys_clk_tick <= 1'b0;
            pll_locked <= 1'b0;
            usb_clk_ready <= 1'b0;
        end else begin
            usb_clk_tick <= usb_br.tick & usb_allowed;
            sys_clk_tick <= sys_br.tick & locked;
            pll_locked <= locked;
            usb_clk_ready <= usb_allowed;
        end
    end

    // Write channel: address and data taken together, one at a time
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(reg_index(s_axi_awaddr)) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control register writes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            osc_ctrl <= RST_OSC_CTRL;
            clk_div <= RST_CLK_DIV;
            rc_tune <= RST_RC_TUNE;
            refo_ctrl <= RST_REFO_CTRL;
            prescale_sel <= RST_PRESCALE;
        end else begin
            // Switch request completes in one cycle; a new write wins
            if (osc_ctrl[OSC_SWITCH_BIT]) begin
                osc_ctrl[OSC_SWITCH_BIT] <= 1'b0;
            end
            if (wr_go) begin
                case (reg_index(s_axi_awaddr))
                    IDX_OSC_CTRL: osc_ctrl <= merge(osc_ctrl, s_axi_wdata, s_axi_wstrb, WMASK_OSC_CTRL);
                    IDX_CLK_DIV: clk_div <= merge(clk_div, s_axi_wdata, s_axi_wstrb, WMASK_CLK_DIV);
                    IDX_RC_TUNE: rc_tune <= merge(rc_tune, s_axi_wdata, s_axi_wstrb, WMASK_RC_TUNE);
                    IDX_REFO_CTRL: refo_ctrl <= merge(refo_ctrl, s_axi_wdata, s_axi_wstrb, WMASK_REFO_CTRL);
                    IDX_USB_CFG: begin
                        if (s_axi_wstrb[0]) begin
                            prescale_sel <= s_axi_wdata[CFG_PRESCALE_LSB +: 3];
                        end
                    end
                    default: begin
                        // Unmapped, answered with an error only
                    end
                endcase
            end
        end
    end

    // Current source follows the requested one on a switch request
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_src <= RST_OSC_CTRL[OSC_CUR_LSB +: 3];
        end else if (osc_ctrl[OSC_SWITCH_BIT]) begin
            cur_src <= osc_ctrl[OSC_NEW_LSB +: 3];
        end
    end

    // Read channel: one read at a time, data registered
    assign rd_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= '0;
                case (reg_index(s_axi_araddr))
                    IDX_OSC_CTRL: begin
                        // Lock bit shows the live multiplier state
                        s_axi_rdata[15:0] <= (osc_ctrl & WMASK_OSC_CTRL)
                            | (16'(cur_src) << OSC_CUR_LSB) | (16'(locked) << OSC_LOCK_BIT);
                    end
                    IDX_CLK_DIV: s_axi_rdata[15:0] <= clk_div;
                    IDX_RC_TUNE: s_axi_rdata[15:0] <= rc_tune;
                    IDX_REFO_CTRL: s_axi_rdata[15:0] <= refo_ctrl;
                    IDX_USB_CFG: begin
                        s_axi_rdata[15:0] <= (16'(prescale_sel) << CFG_PRESCALE_LSB)
                            | (16'(usb_allowed) << CFG_USB_READY_BIT) | (16'(locked) << CFG_SYS_READY_BIT);
                    end
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : ucg_clock_gen

// ### ucg_pkg.sv
// Shared constants for the USB PLL clock generator
package ucg_pkg;

    // Bus geometry
    localparam int AXI_ADDR_W = 16; // Byte address width
    localparam int AXI_DATA_W = 32; // Data width
    localparam int IDX_W = 12; // Register index width
    localparam int IDX_LSB = 2; // Byte address is index times four

    // Register indices, byte address is four times these
    localparam logic [11:0] IDX_OSC_CTRL = 12'h0742; // oscillator_control
    localparam logic [11:0] IDX_CLK_DIV = 12'h0744; // clock_divider_control
    localparam logic [11:0] IDX_RC_TUNE = 12'h0748; // internal_rc_tuning
    localparam logic [11:0] IDX_REFO_CTRL = 12'h074E; // reference_clock_output_control
    localparam logic [11:0] IDX_USB_CFG = 12'h0750; // prescale select and branch status

    // Reset values
    localparam logic [15:0] RST_OSC_CTRL = 16'h0000;
    localparam logic [15:0] RST_CLK_DIV = 16'h0100;
    localparam logic [15:0] RST_RC_TUNE = 16'h0000;
    localparam logic [15:0] RST_REFO_CTRL = 16'h0000;
    localparam logic [2:0] RST_PRESCALE = 3'h0;

    // Writable bit masks, the rest read as zero or status
    localparam logic [15:0] WMASK_OSC_CTRL = 16'h07CF;
    localparam logic [15:0] WMASK_CLK_DIV = 16'hFFE0;
    localparam logic [15:0] WMASK_RC_TUNE = 16'h003F;
    localparam logic [15:0] WMASK_REFO_CTRL = 16'hBF00;
    localparam logic [15:0] WMASK_USB_CFG = 16'h0007;

    // Field positions
    localparam int OSC_CUR_LSB = 12; // Current source, three bits
    localparam int OSC_NEW_LSB = 8; // Requested source, three bits
    localparam int OSC_LOCK_BIT = 5; // PLL lock, read only
    localparam int OSC_SWITCH_BIT = 0; // Switch request
    localparam int SYSTEM_CLOCK_POST_DIVIDE_SELECT_LSB = 6; // system_clock_post_divide_select
    localparam int PLLEN_BIT = 5; // PLL enable
    localparam int CFG_PRESCALE_LSB = 0; // pll_input_prescale_select
    localparam int CFG_USB_READY_BIT = 8; // USB clock running
    localparam int CFG_SYS_READY_BIT = 9; // System branch running

    // Oscillator source codes, values of our own
    localparam logic [2:0] SRC_PRIMARY = 3'h2; // Primary oscillator
    localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3; // Primary oscillator with PLL

    // Clock tree figures
    localparam int SYS_CLK_MHZ = 50; // Rate of sys_clk
    localparam int CLK_PERIOD_NS = 20; // Period of sys_clk
    localparam int REF_MHZ = 4; // Prescaler output
    localparam int PLL_OUT_MHZ = 96; // Multiplier output
    localparam int USB_DIV = 2; // Fixed USB branch divider
    localparam int SYS_DIV = 3; // Fixed system branch divider
    localparam int RATE_W = 12; // Rate accumulator width

    // Reference gap that drops lock
    localparam int REF_GAP_NS = 1000;
    localparam int REF_GAP_CYC = (REF_GAP_NS / CLK_PERIOD_NS < 1) ? 1 : REF_GAP_NS / CLK_PERIOD_NS;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : ucg_pkg

// ### ucg_branch_if.sv
// Rate command and tick of one divider branch
interface ucg_branch_if;
    logic run; // Branch allowed to tick
    logic [ucg_pkg::RATE_W-1:0] inc; // Added each cycle
    logic [ucg_pkg::RATE_W-1:0] modulus; // Wrap point
    logic tick; // One-cycle enable at branch rate

    modport ctrl (output run, output inc, output modulus, input tick);
    modport div (input run, input inc, input modulus, output tick);
endinterface : ucg_branch_if

// ### ucg_rate_divider.sv
// Fractional divider that turns a rate ratio into enable pulses
module ucg_rate_divider #(
    parameter int ACC_W = ucg_pkg::RATE_W
) (
    input wire logic sys_clk,
    input wire logic rstn,
    ucg_branch_if.div br
);
    import ucg_pkg::*;

    // Accumulator must hold the largest modulus
    if (ACC_W < RATE_W) begin : g_bad_width
        $error("ucg_rate_divider: ACC_W too small");
    end

    logic [ACC_W-1:0] acc; // Phase of the branch
    logic [ACC_W:0] sum; // Phase after this cycle

    // Next phase, one bit wider so the wrap is seen
    assign sum = {1'b0, acc} + {1'b0, br.inc};

    // Phase and tick; a stopped branch restarts from zero phase
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc <= '0;
            br.tick <= 1'b0;
        end else if (!br.run) begin
            acc <= '0;
            br.tick <= 1'b0;
        end else if (sum >= {1'b0, br.modulus}) begin
            acc <= ACC_W'(sum - {1'b0, br.modulus});
            br.tick <= 1'b1;
        end else begin
            acc <= sum[ACC_W-1:0];
            br.tick <= 1'b0;
        end
    end

endmodule : ucg_rate_divider

// ### ucg_assertions.sv
// Port-level checker for the USB PLL clock generator
module ucg_assertions #(
    parameter int LOCK_TICKS = 64
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic osc_in,
    input wire logic usb_enable,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_rvalid,
    input wire logic usb_clk_tick,
    input wire logic sys_clk_tick,
    input wire logic pll_locked,
    input wire logic usb_clk_ready
);
    logic osc_q; // Last sampled oscillator level
    logic [6:0] still_cnt; // Cycles the oscillator stood still
    logic [7:0] edge_cnt; // Rising edges seen while unlocked

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // Stillness and edge counters, saturating so they never wrap to a false low
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            osc_q <= 1'b0;
            still_cnt <= 7'h00;
            edge_cnt <= 8'h00;
        end else begin
            osc_q <= osc_in;
            if (osc_q != osc_in) begin
                still_cnt <= 7'h00;
            end else if (still_cnt != 7'h7F) begin
                still_cnt <= still_cnt + 7'h01;
            end
            // Raw edges bound the prescaler's reference ticks from above
            if (pll_locked) begin
                edge_cnt <= 8'h00;
            end else if (osc_in && !osc_q && edge_cnt != 8'hFF) begin
                edge_cnt <= edge_cnt + 8'h01;
            end
        end
    end

    lock_after_ticks_a: assert property ($rose(pll_locked) |-> edge_cnt >= LOCK_TICKS)
        else $error("lock came before enough reference edges");
    lock_drops_still_a: assert property (still_cnt >= 7'h40 |-> !pll_locked)
        else $error("lock held with a still oscillator");
    ready_needs_lock_a: assert property (usb_clk_ready |-> pll_locked || $past(pll_locked))
        else $error("usb clock ready without lock");
    ready_needs_enable_a: assert property (usb_clk_ready |-> $past(usb_enable))
        else $error("usb clock ready while usb disabled");
    usb_tick_gate_a: assert property (usb_clk_tick |-> usb_clk_ready || $past(usb_clk_ready))
        else $error("usb tick outside ready");
    sys_tick_gate_a: assert property (sys_clk_tick |-> pll_locked || $past(pll_locked))
        else $error("system tick without lock");
    // At 32 MHz ticks may pair up, but never three running
    sys_tick_split_a: assert property (sys_clk_tick ##1 sys_clk_tick |=> !sys_clk_tick)
        else $error("system ticks three in a row");
    usb_tick_dense_a: assert property (usb_clk_ready [*5] |-> usb_clk_tick || $past(usb_clk_tick))
        else $error("usb branch missed two ticks running");
    bresp_after_both_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_wvalid))
        else $error("write answered without address and data");
    rdata_after_addr_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
        else $error("read answered without address");
endmodule : ucg_assertions

bind ucg_clock_gen ucg_assertions #(.LOCK_TICKS(LOCK_TICKS)) u_chk (.sys_clk, .rstn, .osc_in, .usb_enable,
    .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_rvalid,
    .usb_clk_tick, .sys_clk_tick, .pll_locked, .usb_clk_ready);

// ### ucg_osc_model.sv
// Behavioural primary oscillator feeding the clock generator
module ucg_osc_model #(
    parameter int HALF_NS = 40 // Half period, well below the synchroniser limit
) (
    input wire logic run,
    output logic osc_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Free toggling while running; a stopped crystal stands still low
    initial begin
        osc_out = 1'b0;
        #7; // Phase unrelated to the bench clock
        forever begin
            #(HALF_NS);
            if (run === 1'b1) begin
                osc_out = ~osc_out;
            end else begin
                osc_out = 1'b0;
            end
        end
    end
endmodule : ucg_osc_model

// ### tb_top.sv
// Self-checking bench for the USB PLL clock generator
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ucg_pkg::*;
    localparam int LT = 4; // Short lock count keeps the run brief
    logic sys_clk, rstn, osc_in, usb_enable, osc_run;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic usb_clk_tick, sys_clk_tick, pll_locked, usb_clk_ready;
    int fails = 0; // Mismatches
    int checks_done = 0; // Comparisons
    int ratio [8] = '{1, 2, 3, 4, 5, 6, 8, 12}; // Prescale divide per select
    int u, s, cyc;

    ucg_clock_gen #(.LOCK_TICKS(LT)) DUT (.sys_clk, .rstn, .osc_in, .usb_enable,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .usb_clk_tick, .sys_clk_tick, .pll_locked, .usb_clk_ready);
    ucg_osc_model #(.HALF_NS(40)) u_osc (.run(osc_run), .osc_out(osc_in));

    // Clock at 50 MHz
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Counts allow one tick of slack for where the window falls
    task automatic near(input int got, input int exp);
        chk(32'(got >= exp - 1 && got <= exp + 1), 32'h0000_0001);
    endtask : near

    // Write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [11:0] idx, input logic [15:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (n < 50) begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 50) begin
            fails++;
            conclude();
        end
        chk(32'(s_axi_bresp), 32'(er));
    endtask : axi_wr

    // Read: data and response taken at the edge rvalid is seen
    task automatic axi_rd(input logic [11:0] idx, input logic [15:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (n < 50) begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 50) begin
            fails++;
            conclude();
        end
        chk(s_axi_rdata, {16'h0000, ed});
        chk(32'(s_axi_rresp), 32'(er));
    endtask : axi_rd

    task automatic wait_lock(output int c);
        c = 0;
        while (pll_locked !== 1'b1 && c < 3000) begin
            @(posedge sys_clk);
            c++;
        end
        if (c == 3000) begin
            fails++;
            conclude();
        end
    endtask : wait_lock

    task automatic count(input int n, output int cu, output int cs);
        cu = 0;
        cs = 0;
        repeat (n) begin
            @(posedge sys_clk);
            if (usb_clk_tick === 1'b1) cu++;
            if (sys_clk_tick === 1'b1) cs++;
        end
    endtask : count

    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        fails++;
        conclude();
    end

    initial begin
        rstn = 1'b0;
        osc_run = 1'b0;
        usb_enable = 1'b0;
        s_axi_awaddr = 16'h0000;
        s_axi_araddr = 16'h0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        // Reset values, unmapped place, writable mask
        axi_rd(IDX_OSC_CTRL, RST_OSC_CTRL, RESP_OKAY);
        axi_rd(IDX_CLK_DIV, RST_CLK_DIV, RESP_OKAY);
        axi_rd(IDX_RC_TUNE, RST_RC_TUNE, RESP_OKAY);
        axi_rd(IDX_REFO_CTRL, RST_REFO_CTRL, RESP_OKAY);
        axi_rd(IDX_USB_CFG, 16'h0000, RESP_OKAY);
        axi_rd(12'h07FF, 16'h0000, RESP_SLVERR);
        axi_wr(12'h07FF, 16'hFFFF, RESP_SLVERR);
        axi_wr(IDX_CLK_DIV, 16'hFFFF, RESP_OKAY);
        axi_rd(IDX_CLK_DIV, WMASK_CLK_DIV, RESP_OKAY);
        axi_wr(IDX_RC_TUNE, 16'hFFFF, RESP_OKAY);
        axi_rd(IDX_RC_TUNE, WMASK_RC_TUNE, RESP_OKAY);
        axi_wr(IDX_REFO_CTRL, 16'hFFFF, RESP_OKAY);
        axi_rd(IDX_REFO_CTRL, WMASK_REFO_CTRL, RESP_OKAY);
        axi_wr(IDX_CLK_DIV, 16'h0000, RESP_OKAY);
        // Locked, but source is not primary: no usb clock
        osc_run <= 1'b1;
        usb_enable <= 1'b1;
        wait_lock(cyc);
        count(150, u, s);
        chk(32'(usb_clk_ready), 32'h0000_0000);
        chk(32'(u), 32'h0000_0000);
        near(s, 96);
        // Both primary source codes allow the usb clock
        foreach (ratio[k]) begin
            if (k < 2) begin
                axi_wr(IDX_OSC_CTRL, {5'h00, SRC_PRIMARY + 3'(k), 8'h01}, RESP_OKAY);
                axi_rd(IDX_OSC_CTRL, {1'b0, SRC_PRIMARY + 3'(k), 1'b0, SRC_PRIMARY + 3'(k), 8'h20}, RESP_OKAY);
                chk(32'(usb_clk_ready), 32'h0000_0001);
                count(100, u, s);
                near(u, 100 * PLL_OUT_MHZ / USB_DIV / SYS_CLK_MHZ);
            end
        end
        // Every post-divide setting
        for (int sel = 0; sel < 4; sel++) begin
            axi_wr(IDX_CLK_DIV, 16'(sel << SYSTEM_CLOCK_POST_DIVIDE_SELECT_LSB), RESP_OKAY);
            count(600, u, s);
            near(s, (600 * (PLL_OUT_MHZ / SYS_DIV) >> sel) / SYS_CLK_MHZ);
            near(u, 600 * PLL_OUT_MHZ / USB_DIV / SYS_CLK_MHZ);
        end
        // Every prescale select: lock time scales with its divide
        axi_wr(IDX_OSC_CTRL, {5'h00, SRC_PRIMARY, 8'h01}, RESP_OKAY);
        foreach (ratio[k]) begin
            usb_enable <= 1'b0;
            repeat (60) @(posedge sys_clk);
            chk(32'(pll_locked), 32'h0000_0000);
            axi_wr(IDX_USB_CFG, 16'(k), RESP_OKAY);
            usb_enable <= 1'b1;
            wait_lock(cyc);
            chk(32'(cyc >= ratio[k] * (LT - 1) * 4 - 4 && cyc <= ratio[k] * LT * 4 + 16), 32'h0000_0001);
        end
        // Status word: last select, usb and system branches running
        axi_rd(IDX_USB_CFG, 16'h0007 | 16'(1 << CFG_USB_READY_BIT) | 16'(1 << CFG_SYS_READY_BIT), RESP_OKAY);
        // Oscillator stops: lock and both branches go quiet
        osc_run <= 1'b0;
        repeat (80) @(posedge sys_clk);
        count(20, u, s);
        chk(32'(pll_locked), 32'h0000_0000);
        chk(32'(usb_clk_ready), 32'h0000_0000);
        chk(32'(u + s), 32'h0000_0000);
        conclude();
    end
endmodule : tb_top
